// *** design/crf_bank.sv ***
// Two copies of the banked data, address and frame base words
`timescale 1ns/1ns
module crf_bank (
  input  wire logic aclk,
  crf_bank_if.store b
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage: one array row per bank; the caller gates writes with ce
  logic [15:0] mem [2][crf_pkg::BANK_REGS];

  // Only the selected bank row is touched, the other keeps its words
  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < crf_pkg::BANK_REGS; i++)
    begin
      if (b.wr_sel[i])
      begin
        mem[b.bank][i] <= b.wr_word[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port shows the active bank
  genvar g;
  generate
    for (g = 0; g < crf_pkg::BANK_REGS; g++)
    begin : g_rd
      assign b.rd_word[g] = mem[b.bank][g];
    end
  endgenerate

endmodule : crf_bank

// *** design/crf_top.sv ***
// Banked CPU register file with stack select and priority level flags
`timescale 1ns/1ns
module crf_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              irq_req,
  input  wire logic [2:0]        irq_prio,
  output logic                   irq_accept,
  input  wire logic              trap_exec,
  input  wire logic [5:0]        trap_vector,
  output logic                   stack_sel,
  output logic [2:0]             proc_priority_level,
  output logic [15:0]            active_sp,
  output logic                   bank_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Merge a halfword under two byte strobes
  function automatic logic [15:0] crf_merge(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0]  be);
    crf_merge = old_v;
    if (be[0])
      crf_merge[7:0] = new_v[7:0];
    if (be[1])
      crf_merge[15:8] = new_v[15:8];
  endfunction : crf_merge

  // Word-aligned register offset of a bus address
  function automatic logic [7:0] crf_off(input logic [ADDR_W-1:0] a);
    logic [7:0] w;
    w = 8'(a);
    crf_off = {w[7:2], 2'h0};
  endfunction : crf_off

  ////////////////////////////////////////////////////////////////////////////
  // Storage and bank switching
  crf_bank_if bif ();

  crf_bank u_bank (
    .aclk (aclk),
    .b    (bif.store)
  );

  assign bif.bank = bank_sel;

  logic [15:0]           irq_stack_ptr;
  logic [15:0]           app_stack_ptr;
  crf_pkg::crf_wr_state_t ws;
  logic                  aw_full;
  logic                  w_full;
  logic [7:0]            wr_off;
  logic [31:0]           wr_dat;
  logic [3:0]            wr_stb;
  logic                  wr_commit;
  logic                  wr_ok;
  logic [7:0]            rd_off;
  logic [31:0]           rd_value;
  logic                  rd_ok;
  logic                  irq_gate;
  logic                  trap_clear;
  logic                  hw_clear;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  assign wr_commit = ce && (ws == crf_pkg::WS_COLLECT) && aw_full && w_full;

  // Address and data holding registers; ready drops while one is held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      awready <= 1'b1;
      wready  <= 1'b1;
      wr_off  <= 8'h00;
      wr_dat  <= 32'h0000_0000;
      wr_stb  <= 4'h0;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        aw_full <= 1'b1;
        awready <= 1'b0;
        wr_off  <= crf_off(awaddr);
      end
      if (wvalid && wready)
      begin
        w_full <= 1'b1;
        wready <= 1'b0;
        wr_dat <= wdata;
        wr_stb <= wstrb;
      end
      if (bvalid && bready)
      begin
        aw_full <= 1'b0;
        w_full  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Response follows both halves by one cycle and holds until taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ws     <= crf_pkg::WS_COLLECT;
      bvalid <= 1'b0;
      bresp  <= crf_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      case (ws)
        crf_pkg::WS_COLLECT:
        begin
          if (wr_commit)
          begin
            ws     <= crf_pkg::WS_RESP;
            bvalid <= 1'b1;
            bresp  <= wr_ok ? crf_pkg::RESP_OKAY : crf_pkg::RESP_SLVERR;
          end
        end
        crf_pkg::WS_RESP:
        begin
          if (bready)
          begin
            ws     <= crf_pkg::WS_COLLECT;
            bvalid <= 1'b0;
          end
        end
        default:
        begin
          ws     <= crf_pkg::WS_COLLECT;
          bvalid <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write decode into the active bank; unwritten words keep their value
  always_comb
  begin
    bif.wr_sel = 7'h00;
    for (int i = 0; i < crf_pkg::BANK_REGS; i++)
      bif.wr_word[i] = bif.rd_word[i];
    wr_ok = 1'b1;
    case (wr_off)
      crf_pkg::OFF_DATA_A, crf_pkg::OFF_DATA_B, crf_pkg::OFF_DATA_C,
      crf_pkg::OFF_DATA_D, crf_pkg::OFF_ADDR_0, crf_pkg::OFF_ADDR_1,
      crf_pkg::OFF_FRAME:
      begin
        // Byte lanes 0 and 1 reach the low and high halves
        bif.wr_sel[wr_off[4:2]] = 1'b1;
        bif.wr_word[wr_off[4:2]] =
          crf_merge(bif.rd_word[wr_off[4:2]], wr_dat[15:0],
                    wr_stb[1:0]);
      end
      crf_pkg::OFF_PAIR_CA:
      begin
        bif.wr_sel[crf_pkg::IDX_A] = 1'b1;
        bif.wr_sel[crf_pkg::IDX_C] = 1'b1;
        bif.wr_word[crf_pkg::IDX_A] =
          crf_merge(bif.rd_word[crf_pkg::IDX_A], wr_dat[15:0],
                    wr_stb[1:0]);
        bif.wr_word[crf_pkg::IDX_C] =
          crf_merge(bif.rd_word[crf_pkg::IDX_C], wr_dat[31:16],
                    wr_stb[3:2]);
      end
      crf_pkg::OFF_PAIR_DB:
      begin
        bif.wr_sel[crf_pkg::IDX_B] = 1'b1;
        bif.wr_sel[crf_pkg::IDX_D] = 1'b1;
        bif.wr_word[crf_pkg::IDX_B] =
          crf_merge(bif.rd_word[crf_pkg::IDX_B], wr_dat[15:0],
                    wr_stb[1:0]);
        bif.wr_word[crf_pkg::IDX_D] =
          crf_merge(bif.rd_word[crf_pkg::IDX_D], wr_dat[31:16],
                    wr_stb[3:2]);
      end
      crf_pkg::OFF_IRQ_SP, crf_pkg::OFF_APP_SP, crf_pkg::OFF_FLAGS:
        wr_ok = 1'b1;
      default:
        wr_ok = 1'b0;
    endcase
    if (!wr_commit)
      bif.wr_sel = 7'h00;
  end

  // Stack pointers live outside the banks
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stack_ptr <= crf_pkg::RST_SP;
      app_stack_ptr <= crf_pkg::RST_SP;
    end
    else if (wr_commit && wr_off == crf_pkg::OFF_IRQ_SP)
      irq_stack_ptr <= crf_merge(irq_stack_ptr, wr_dat[15:0], wr_stb[1:0]);
    else if (wr_commit && wr_off == crf_pkg::OFF_APP_SP)
      app_stack_ptr <= crf_merge(app_stack_ptr, wr_dat[15:0], wr_stb[1:0]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt gating and stack flag
  assign irq_gate   = irq_req && (irq_prio > proc_priority_level);
  assign trap_clear = trap_exec &&
                      (trap_vector < crf_pkg::TRAP_CLEAR_LIMIT);
  assign hw_clear   = (irq_gate && !irq_accept) || trap_clear;

  // One pulse per request; the requester drops irq_req on seeing it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_accept <= 1'b0;
    else if (ce)
      irq_accept <= irq_gate && !irq_accept;
  end

  // Hardware clear beats a software write in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stack_sel           <= crf_pkg::RST_STACK;
      proc_priority_level <= crf_pkg::RST_LEVEL;
      bank_sel            <= crf_pkg::RST_BANK;
    end
    else if (ce)
    begin
      if (wr_commit && wr_off == crf_pkg::OFF_FLAGS)
      begin
        // Reserved bit is dropped on write
        if (wr_stb[0])
        begin
          bank_sel            <= wr_dat[crf_pkg::FLG_BANK];
          stack_sel           <= wr_dat[crf_pkg::FLG_STACK];
          proc_priority_level <=
            wr_dat[crf_pkg::FLG_LVL_HI:crf_pkg::FLG_LVL_LO];
        end
      end
      if (ce && hw_clear)
        stack_sel <= 1'b0;
    end
  end

  // Active pointer follows the flag one cycle later
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      active_sp <= crf_pkg::RST_SP;
    else if (ce)
      active_sp <= stack_sel ? app_stack_ptr : irq_stack_ptr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: answer one cycle after the address is taken
  assign rd_off = crf_off(araddr);

  always_comb
  begin
    rd_value = 32'h0000_0000;
    rd_ok    = 1'b1;
    case (rd_off)
      crf_pkg::OFF_DATA_A, crf_pkg::OFF_DATA_B, crf_pkg::OFF_DATA_C,
      crf_pkg::OFF_DATA_D, crf_pkg::OFF_ADDR_0, crf_pkg::OFF_ADDR_1,
      crf_pkg::OFF_FRAME:
        rd_value[15:0] = bif.rd_word[rd_off[4:2]];
      crf_pkg::OFF_IRQ_SP:
        rd_value[15:0] = irq_stack_ptr;
      crf_pkg::OFF_APP_SP:
        rd_value[15:0] = app_stack_ptr;
      crf_pkg::OFF_FLAGS:
      begin
        // Reserved bit reads zero so software never sees noise
        rd_value[crf_pkg::FLG_BANK]  = bank_sel;
        rd_value[crf_pkg::FLG_STACK] = stack_sel;
        rd_value[crf_pkg::FLG_LVL_HI:crf_pkg::FLG_LVL_LO] =
          proc_priority_level;
      end
      crf_pkg::OFF_PAIR_CA:
        rd_value = {bif.rd_word[crf_pkg::IDX_C],
                    bif.rd_word[crf_pkg::IDX_A]};
      crf_pkg::OFF_PAIR_DB:
        rd_value = {bif.rd_word[crf_pkg::IDX_D],
                    bif.rd_word[crf_pkg::IDX_B]};
      crf_pkg::OFF_ACT_SP:
        rd_value[15:0] = active_sp;
      default:
        rd_ok = 1'b0;
    endcase
  end

  // Only one read in flight; arready returns after rvalid is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= crf_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_value;
        rresp   <= rd_ok ? crf_pkg::RESP_OKAY : crf_pkg::RESP_SLVERR;
      end
      else if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [7:0] rd_off_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rd_off_q <= 8'h00;
    else if (ce && arvalid && arready)
      rd_off_q <= rd_off;
  end

  sequence ar_taken_s;
    ce && arvalid && arready;
  endsequence

  sequence wr_both_s;
    wr_commit;
  endsequence

  irq_stack_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_accept |-> !stack_sel)
    else $error("stack flag set after interrupt accept");

  trap_stack_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && trap_exec && trap_vector < 6'h20 |=> !stack_sel)
    else $error("stack flag set after low trap");

  accept_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(irq_accept) |->
      $past(irq_prio) > $past(proc_priority_level))
    else $error("request accepted at or below level");

  sp_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && stack_sel ##1 ce && stack_sel |->
      active_sp == $past(app_stack_ptr))
    else $error("active pointer not user pointer");

  read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_taken_s |=> rvalid && !arready)
    else $error("read answer not one cycle after address");

  write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_both_s |=> bvalid ##0 (bvalid throughout (!bready [*1])) or bvalid)
    else $error("write answer not one cycle after both halves");

  reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && rd_off_q == crf_pkg::OFF_FLAGS |->
      rdata[crf_pkg::FLG_RSV] == 1'b0)
    else $error("reserved flag bit read nonzero");

  byte_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_both_s and (wr_off == crf_pkg::OFF_DATA_A && wr_stb[1:0] == 2'h1)
    |=> bif.rd_word[crf_pkg::IDX_A][15:8] ==
        $past(bif.rd_word[crf_pkg::IDX_A][15:8]))
    else $error("low byte write altered high half");

  bank_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && $changed(bank_sel) ##1 ce && $changed(bank_sel) && !wr_commit
    && !$past(wr_commit) |->
      bif.rd_word[crf_pkg::IDX_FB] ==
      $past(bif.rd_word[crf_pkg::IDX_FB], 2))
    else $error("bank switch altered contents");

endmodule : crf_top

// *** include/crf_bank_if.sv ***
// Interface between the register file control and the bank storage
`timescale 1ns/1ns
interface crf_bank_if;
  logic        bank;
  logic [6:0]  wr_sel;
  logic [15:0] wr_word [7];
  logic [15:0] rd_word [7];

  modport ctl   (output bank, output wr_sel, output wr_word, input rd_word);
  modport store (input bank, input wr_sel, input wr_word, output rd_word);
endinterface : crf_bank_if

// *** include/crf_pkg.sv ***
// Package of constants and types for the banked CPU register file
package crf_pkg;

  // Register counts
  localparam int BANK_REGS = 7;
  localparam int VISIBLE_REGS = 13;

  // Word positions inside one bank
  localparam int IDX_A  = 0;
  localparam int IDX_B  = 1;
  localparam int IDX_C  = 2;
  localparam int IDX_D  = 3;
  localparam int IDX_A0 = 4;
  localparam int IDX_A1 = 5;
  localparam int IDX_FB = 6;

  // Byte offsets on the register bus
  localparam logic [7:0] OFF_DATA_A  = 8'h00;
  localparam logic [7:0] OFF_DATA_B  = 8'h04;
  localparam logic [7:0] OFF_DATA_C  = 8'h08;
  localparam logic [7:0] OFF_DATA_D  = 8'h0c;
  localparam logic [7:0] OFF_ADDR_0  = 8'h10;
  localparam logic [7:0] OFF_ADDR_1  = 8'h14;
  localparam logic [7:0] OFF_FRAME   = 8'h18;
  localparam logic [7:0] OFF_IRQ_SP  = 8'h1c;
  localparam logic [7:0] OFF_APP_SP  = 8'h20;
  localparam logic [7:0] OFF_FLAGS   = 8'h24;
  localparam logic [7:0] OFF_PAIR_CA = 8'h2c;
  localparam logic [7:0] OFF_PAIR_DB = 8'h30;
  localparam logic [7:0] OFF_ACT_SP  = 8'h34;

  // Flag register fields
  localparam int FLG_BANK  = 0;
  localparam int FLG_RSV   = 1;
  localparam int FLG_STACK = 2;
  localparam int FLG_LVL_LO = 4;
  localparam int FLG_LVL_HI = 6;

  // Values after reset
  localparam logic [15:0] RST_SP    = 16'h0000;
  localparam logic [2:0]  RST_LEVEL = 3'h0;
  localparam logic        RST_STACK = 1'b0;
  localparam logic        RST_BANK  = 1'b0;

  // Trap vectors below this clear the stack select flag
  localparam logic [5:0] TRAP_CLEAR_LIMIT = 6'h20;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Write channel state
  typedef enum logic {WS_COLLECT, WS_RESP} crf_wr_state_t;

endpackage : crf_pkg

// *** sim/crf_tb.sv ***
// Self-checking bench for the banked CPU register file
`timescale 1ns/1ns
module tb;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  localparam logic [31:0] NRSV = 32'hffff_fffd;
  localparam logic [1:0]  OK = crf_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR = crf_pkg::RESP_SLVERR;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        awready;
  logic        wready;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        wvalid = 1'b0;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  logic        irq_req = 1'b0;
  logic [2:0]  irq_prio = 3'h0;
  logic        irq_accept;
  logic        trap_exec = 1'b0;
  logic [5:0]  trap_vector = 6'h00;
  logic        stack_sel;
  logic [2:0]  proc_priority_level;
  logic [15:0] active_sp;
  logic        bank_sel;
  int          fail_count = 0;
  int          num_checks = 0;

  crf_top crf_top_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq_req(irq_req), .irq_prio(irq_prio), .irq_accept(irq_accept),
    .trap_exec(trap_exec), .trap_vector(trap_vector),
    .stack_sel(stack_sel), .proc_priority_level(proc_priority_level),
    .active_sp(active_sp), .bank_sel(bank_sel));

  // Free-running core clock, 50 ns period
  always #25 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks, one for values and one for bus responses
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp,
                          input string what);
    chk({30'h0, got}, {30'h0, exp}, what);
  endtask : chk_resp

  ////////////////////////////////////////////////////////////////////////////
  // Bus master; no fixed latency is assumed, only the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    bit aw_ok;
    bit w_ok;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    forever
    begin
      @(posedge aclk);
      if (awready === 1'b1 && !aw_ok)
      begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (wready === 1'b1 && !w_ok)
      begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
      if (bvalid === 1'b1 && aw_ok && w_ok)
      begin
        bready <= 1'b0;
        chk_resp(bresp, er, "write response");
        break;
      end
    end
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic [31:0] m, input logic [1:0] er);
    bit ar_ok;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar_ok = 1'b0;
    forever
    begin
      @(posedge aclk);
      if (arready === 1'b1 && !ar_ok)
      begin
        arvalid <= 1'b0;
        ar_ok = 1'b1;
      end
      if (rvalid === 1'b1 && ar_ok)
      begin
        rready <= 1'b0;
        chk(rdata & m, exp, "read data");
        chk_resp(rresp, er, "read response");
        break;
      end
    end
  endtask : rd_chk

  // Flag word; the reserved bit is always written as zero
  function automatic logic [31:0] flg(input logic b, input logic s,
                                      input logic [2:0] l);
    return {25'h0, l, 1'b0, s, 1'b0, b};
  endfunction : flg

  // Distinct pattern per bank and word; bank one is the inverse
  function automatic logic [15:0] pat(input int b, input int i);
    return 16'((i + 1) * 16'h1111) ^ {16{b[0]}};
  endfunction : pat

  // Offers one request and counts the accept pulses that follow
  task automatic irq_try(input logic [2:0] p, input int exp);
    int k;
    int cnt;
    cnt = 0;
    @(posedge aclk);
    irq_req <= 1'b1;
    irq_prio <= p;
    for (k = 0; k < 4; k++)
    begin
      @(posedge aclk);
      if (irq_accept === 1'b1)
        cnt++;
      if (k == 1)
        irq_req <= 1'b0;
    end
    chk(cnt, exp, "accept pulses");
  endtask : irq_try

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk({11'h0, bank_sel, stack_sel, proc_priority_level, active_sp}, 32'h0,
        "reset outputs");
    rd_chk(crf_pkg::OFF_FLAGS, 32'h0, NRSV, OK);
    rd_chk(crf_pkg::OFF_APP_SP, 32'h0, ALL, OK);
  endtask : t_reset

  task automatic t_banks();
    for (int b = 0; b < 2; b++)
    begin
      wr(crf_pkg::OFF_FLAGS, flg(b[0], 1'b0, 3'h0), 4'h1, OK);
      for (int i = 0; i < 7; i++)
        wr(8'(i * 4), {16'h0, pat(b, i)}, 4'h3, OK);
    end
    for (int b = 0; b < 2; b++)
    begin
      wr(crf_pkg::OFF_FLAGS, flg(b[0], 1'b0, 3'h0), 4'h1, OK);
      chk({31'h0, bank_sel}, 32'(b), "bank output");
      for (int i = 0; i < 7; i++)
        rd_chk(8'(i * 4), {16'h0, pat(b, i)}, ALL, OK);
    end
    wr(crf_pkg::OFF_FLAGS, flg(1'b0, 1'b0, 3'h0), 4'h1, OK);
  endtask : t_banks

  task automatic t_bytes();
    logic [15:0] p;
    for (int i = 0; i < 2; i++)
    begin
      p = pat(0, i);
      wr(8'(i * 4), 32'h0000_00ab, 4'h1, OK);
      rd_chk(8'(i * 4), {16'h0, p[15:8], 8'hab}, ALL, OK);
      wr(8'(i * 4), 32'h0000_cd00, 4'h2, OK);
      rd_chk(8'(i * 4), 32'h0000_cdab, ALL, OK);
    end
  endtask : t_bytes

  task automatic t_pairs();
    rd_chk(crf_pkg::OFF_PAIR_CA, {pat(0, 2), 16'hcdab}, ALL, OK);
    wr(crf_pkg::OFF_PAIR_DB, 32'h1234_5678, 4'hf, OK);
    wr(crf_pkg::OFF_PAIR_DB, 32'h00ee_0000, 4'h4, OK);
    rd_chk(crf_pkg::OFF_DATA_D, 32'h0000_12ee, ALL, OK);
    rd_chk(crf_pkg::OFF_DATA_B, 32'h0000_5678, ALL, OK);
  endtask : t_pairs

  task automatic t_stack();
    wr(crf_pkg::OFF_IRQ_SP, 32'h0000_0a0a, 4'h3, OK);
    wr(crf_pkg::OFF_APP_SP, 32'h0000_0b0b, 4'h3, OK);
    for (int s = 1; s >= 0; s--)
    begin
      wr(crf_pkg::OFF_FLAGS, flg(1'b0, s[0], 3'h0), 4'h1, OK);
      // Pointer output lags the flag by one cycle
      repeat (2) @(posedge aclk);
      chk({16'h0, active_sp}, s ? 32'h0b0b : 32'h0a0a, "active sp");
      rd_chk(crf_pkg::OFF_ACT_SP, s ? 32'h0b0b : 32'h0a0a, ALL, OK);
    end
  endtask : t_stack

  task automatic t_clear();
    int vec [4] = '{31, 32, 0, 63};
    foreach (vec[i])
    begin
      wr(crf_pkg::OFF_FLAGS, flg(1'b0, 1'b1, 3'h0), 4'h1, OK);
      @(posedge aclk);
      trap_exec <= 1'b1;
      trap_vector <= 6'(vec[i]);
      @(posedge aclk);
      trap_exec <= 1'b0;
      @(posedge aclk);
      chk({31'h0, stack_sel}, vec[i] < 32 ? 32'h0 : 32'h1, "trap");
    end
    wr(crf_pkg::OFF_FLAGS, flg(1'b0, 1'b1, 3'h2), 4'h1, OK);
    irq_try(3'h5, 1);
    chk({31'h0, stack_sel}, 32'h0, "accept clears flag");
    chk({29'h0, proc_priority_level}, 32'h2, "level kept");
  endtask : t_clear

  // A low trap while the clock enable is low must leave the flag alone
  task automatic t_freeze();
    wr(crf_pkg::OFF_FLAGS, flg(1'b0, 1'b1, 3'h0), 4'h1, OK);
    @(posedge aclk);
    ce <= 1'b0;
    trap_exec <= 1'b1;
    trap_vector <= 6'h00;
    @(posedge aclk);
    trap_exec <= 1'b0;
    @(posedge aclk);
    ce <= 1'b1;
    @(posedge aclk);
    chk({31'h0, stack_sel}, 32'h1, "frozen flag");
    wr(crf_pkg::OFF_FLAGS, flg(1'b0, 1'b0, 3'h0), 4'h1, OK);
  endtask : t_freeze

  task automatic t_prio();
    for (int l = 0; l < 8; l++)
    begin
      wr(crf_pkg::OFF_FLAGS, flg(1'b0, 1'b0, 3'(l)), 4'h1, OK);
      rd_chk(crf_pkg::OFF_FLAGS, flg(1'b0, 1'b0, 3'(l)), NRSV, OK);
      for (int p = 0; p < 8; p++)
        irq_try(3'(p), (p > l) ? 1 : 0);
    end
  endtask : t_prio

  task automatic t_errors();
    wr(8'h28, 32'h0000_5555, 4'hf, ERR);
    rd_chk(8'h28, 32'h0, ALL, ERR);
    // Active pointer is read-only, a write must not disturb it
    wr(crf_pkg::OFF_ACT_SP, 32'h0000_ffff, 4'h3, ERR);
    rd_chk(crf_pkg::OFF_ACT_SP, 32'h0000_0a0a, ALL, OK);
  endtask : t_errors

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_banks();
    t_bytes();
    t_pairs();
    t_stack();
    t_clear();
    t_freeze();
    t_prio();
    t_errors();
    wrap_up();
  end

  // Watchdog, well above the fewer than a thousand cycles the run needs
  initial
  begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    wrap_up();
  end
endmodule : tb
